/* File: iopc_assertions.sv */
// checker for bus handshake order and capture interrupt behaviour of the protect and capture block
`timescale 1ns/100ps
`include "iopc_map.svh"
module iopc_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        rx_transfer_end,
  input wire logic        rx_buffer_full,
  input wire logic        cap_irq
);
  logic [3:0] mask_reg;
  logic [3:0] mask_next;
  logic       wr_take;
  // shadow mask from whole-word writes; it leads the design by an edge, so checks wait three cycles
  assign wr_take   = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign mask_next = (s_axi_awaddr == `IOPC_A_IEN) ? (mask_reg | s_axi_wdata[3:0]) :
                     (s_axi_awaddr == `IOPC_A_IDIS) ? (mask_reg & ~s_axi_wdata[3:0]) : mask_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) mask_reg <= 4'h0;
    else if (wr_take) mask_reg <= mask_next;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response changed before it was taken");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  a_write_answer: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while a response is pending");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data is pending");
  a_irq_full: assert property ((rx_buffer_full && mask_reg[3])[*3] |-> cap_irq)
    else $error("buffer full enabled but no interrupt");
  a_irq_end: assert property ((rx_transfer_end && mask_reg[2])[*3] |-> cap_irq)
    else $error("transfer end enabled but no interrupt");
  a_irq_quiet: assert property ((!rx_transfer_end && !rx_buffer_full && mask_reg == 4'h0)[*3] |-> !cap_irq)
    else $error("interrupt with every source masked");
endmodule
bind iopc_top iopc_assertions u_iopc_assertions (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_transfer_end, .rx_buffer_full, .cap_irq);

/* File: iopc_cap_src.sv */
// model of the external parallel source and the receive dma status lines
`timescale 1ns/100ps
module iopc_cap_src (
  input  wire logic       aclk,
  output logic      [7:0] cap_data,
  output logic            cap_strobe,
  output logic            cap_den1,
  output logic            cap_den2,
  output logic            rx_transfer_end,
  output logic            rx_buffer_full
);
  // idle levels; the data bus has no pull, so it never rests on the last byte
  initial begin
    cap_data        = 8'hFF;
    cap_strobe      = 1'b0;
    cap_den1        = 1'b0;
    cap_den2        = 1'b0;
    rx_transfer_end = 1'b0;
    rx_buffer_full  = 1'b0;
  end
  // one sample for one cycle, then the inverse byte and gap idle cycles
  task automatic send(input logic [7:0] d, input logic den, input int gap);
    @(posedge aclk);
    cap_data   <= d;
    cap_strobe <= 1'b1;
    cap_den1   <= den;
    cap_den2   <= den;
    @(posedge aclk);
    cap_data   <= ~d;
    cap_strobe <= 1'b0;
    cap_den1   <= 1'b0;
    cap_den2   <= 1'b0;
    repeat (gap) @(posedge aclk);
  endtask
  // dma status levels
  task automatic dma(input logic e, input logic f);
    @(posedge aclk);
    rx_transfer_end <= e;
    rx_buffer_full  <= f;
  endtask
endmodule

/* File: iopc_map.svh */
// register addresses, field positions and reset values of the protect and capture block
`ifndef IOPC_MAP_SVH
`define IOPC_MAP_SVH

// controller base and register byte addresses
`define IOPC_BASE        32'h400E0E00
`define IOPC_A_LOCK      32'h400E0EE0
`define IOPC_A_WPMODE    32'h400E0EE4
`define IOPC_A_WPSTAT    32'h400E0EE8
`define IOPC_A_HYST      32'h400E0F00
`define IOPC_A_CMODE     32'h400E0F50
`define IOPC_A_IEN       32'h400E0F54
`define IOPC_A_IDIS      32'h400E0F58
`define IOPC_A_IMASK     32'h400E0F5C
`define IOPC_A_ISTAT     32'h400E0F60
`define IOPC_A_HOLD      32'h400E0F64

// write protection fields
`define IOPC_KEY_VALUE   24'h50494F
`define IOPC_KEY_MSB     31
`define IOPC_KEY_LSB     8
`define IOPC_PEN_BIT     0
`define IOPC_VFLAG_BIT   0
`define IOPC_VOFS_MSB    23
`define IOPC_VOFS_LSB    8

// capture mode fields
`define IOPC_CEN_BIT     0
`define IOPC_WID_MSB     5
`define IOPC_WID_LSB     4
`define IOPC_ALW_BIT     9
`define IOPC_ALT_BIT     10
`define IOPC_PH_BIT      11
`define IOPC_CMODE_WMASK 32'h00000E31

// capture interrupt bits
`define IOPC_IRQ_W       4
`define IOPC_IRQ_RDY     0
`define IOPC_IRQ_OVR     1
`define IOPC_IRQ_END     2
`define IOPC_IRQ_FULL    3

// reset values
`define IOPC_HYST_RST    32'h00000000
`define IOPC_CMODE_RST   32'h00000000
`define IOPC_MASK_RST    4'h0

// bus answers
`define IOPC_RESP_OK     2'h0
`define IOPC_RESP_ERR    2'h2

`endif

/* File: iopc_pkg.sv */
// types shared by the protect and capture block
package iopc_pkg;
  typedef enum logic [1:0] {
    IOPC_W8   = 2'h0,
    IOPC_W16  = 2'h1,
    IOPC_W32  = 2'h2,
    IOPC_WRSV = 2'h3
  } iopc_width_t;
endpackage

/* File: iopc_top.sv */
// line lock status, write protection, hysteresis control and parallel capture with axi4-lite registers
`timescale 1ns/100ps
`include "iopc_map.svh"

module iopc_top #(
  parameter int LINES = 32
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output wire logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output wire logic              s_axi_wready,
  output wire logic [1:0]        s_axi_bresp,
  output wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output wire logic              s_axi_arready,
  output wire logic [31:0]       s_axi_rdata,
  output wire logic [1:0]        s_axi_rresp,
  output wire logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [LINES-1:0]  line_locked,
  output wire logic [LINES-1:0]  hysteresis_off,
  input  wire logic [7:0]        cap_data,
  input  wire logic              cap_strobe,
  input  wire logic              cap_den1,
  input  wire logic              cap_den2,
  input  wire logic              rx_transfer_end,
  input  wire logic              rx_buffer_full,
  output wire logic              cap_irq
);

  // refuse line counts the register layout cannot hold
  // lines above the parameter read back as zero in the lock and hysteresis words
  if (LINES < 1 || LINES > 32) begin : g_bad_lines
    $error("iopc_top: LINES must lie between 1 and 32");
  end

  logic        aw_full_reg;
  logic [31:0] aw_addr_reg;
  logic        w_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  logic                   pen_reg;
  logic                   vflag_reg;
  logic [15:0]            vofs_reg;
  logic [LINES-1:0]       hyst_reg;
  logic [31:0]            cmode_reg;
  logic [`IOPC_IRQ_W-1:0] mask_reg;
  logic                   rdy_reg;
  logic                   ovr_reg;
  logic                   irq_reg;
  logic                   idx_reg;
  logic [1:0]             cnt_reg;
  logic [31:0]            pack_reg;
  logic [31:0]            hold_reg;

  // write address and data are held independently, so either may come first
  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready  = !w_full_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  wire   wr_go         = aw_full_reg && w_full_reg && !bvalid_reg;

  // byte strobes expanded to a bit mask; partial writes touch only enabled lanes, except that a keyed WPMODE write without lane 0 clears pen_reg
  logic [31:0] wmask;
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{w_strb_reg[b]}};
  end
  wire [31:0] wd = w_data_reg & wmask;

  // write decode
  // only the capture mode word is guarded; hysteresis and mask stay writable under protection
  wire wa_lock  = aw_addr_reg == `IOPC_A_LOCK;
  wire wa_wpm   = aw_addr_reg == `IOPC_A_WPMODE;
  wire wa_wps   = aw_addr_reg == `IOPC_A_WPSTAT;
  wire wa_hyst  = aw_addr_reg == `IOPC_A_HYST;
  wire wa_cmode = aw_addr_reg == `IOPC_A_CMODE;
  wire wa_ien   = aw_addr_reg == `IOPC_A_IEN;
  wire wa_idis  = aw_addr_reg == `IOPC_A_IDIS;
  wire wa_ro    = aw_addr_reg == `IOPC_A_IMASK || aw_addr_reg == `IOPC_A_ISTAT || aw_addr_reg == `IOPC_A_HOLD;
  wire wr_hit   = wa_lock || wa_wpm || wa_wps || wa_hyst || wa_cmode || wa_ien || wa_idis || wa_ro;
  wire key_ok   = wd[`IOPC_KEY_MSB:`IOPC_KEY_LSB] == `IOPC_KEY_VALUE;
  wire cmode_we = wr_go && wa_cmode && !pen_reg;
  wire viol     = wr_go && wa_cmode && pen_reg;

  // write channel handshake and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 32'h00000000;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `IOPC_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_reg <= 1'b0;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? `IOPC_RESP_OK : `IOPC_RESP_ERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read path: one outstanding read, data registered
  // clearing reads act at the edge that takes the address, the same edge that loads the data
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  wire   rd_go         = s_axi_arvalid && !rvalid_reg;
  wire   rd_wps        = rd_go && s_axi_araddr == `IOPC_A_WPSTAT;
  wire   rd_istat      = rd_go && s_axi_araddr == `IOPC_A_ISTAT;
  wire   rd_hold       = rd_go && s_axi_araddr == `IOPC_A_HOLD;

  // readable views of block state
  // the violation offset outlives its flag and is only replaced by the next violation
  wire [31:0] lock_w  = 32'(line_locked);
  wire [31:0] hyst_w  = 32'(hyst_reg);
  wire [31:0] wpm_w   = {31'h00000000, pen_reg};
  wire [31:0] wps_w   = {8'h00, vofs_reg, 7'h00, vflag_reg};
  wire [31:0] mask_w  = 32'(mask_reg);
  wire [3:0]  stat_w  = {rx_buffer_full, rx_transfer_end, ovr_reg, rdy_reg};
  wire [31:0] istat_w = 32'(stat_w);

  // read multiplexer; write-only and unmapped words read as zero
  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `IOPC_A_LOCK:   rd_word = lock_w;
      `IOPC_A_WPMODE: rd_word = wpm_w;
      `IOPC_A_WPSTAT: rd_word = wps_w;
      `IOPC_A_HYST:   rd_word = hyst_w;
      `IOPC_A_CMODE:  rd_word = cmode_reg;
      `IOPC_A_IEN:    rd_word = 32'h00000000;
      `IOPC_A_IDIS:   rd_word = 32'h00000000;
      `IOPC_A_IMASK:  rd_word = mask_w;
      `IOPC_A_ISTAT:  rd_word = istat_w;
      `IOPC_A_HOLD:   rd_word = hold_reg;
      default:        rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `IOPC_RESP_OK;
    end else if (rd_go) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_hit ? `IOPC_RESP_OK : `IOPC_RESP_ERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // protection, violation report, hysteresis and interrupt mask
  // the key is compared on strobed lanes only, so a write that leaves out any key lane is ignored
  // a violation and a status read in one cycle keep the flag set, so no event is lost
  wire [`IOPC_IRQ_W-1:0] en_bits  = wr_go && wa_ien ? wd[`IOPC_IRQ_W-1:0] : 4'h0;
  wire [`IOPC_IRQ_W-1:0] dis_bits = wr_go && wa_idis ? wd[`IOPC_IRQ_W-1:0] : 4'h0;
  wire [31:0]            vofs_w   = aw_addr_reg - `IOPC_BASE;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pen_reg   <= 1'b0;
      vflag_reg <= 1'b0;
      vofs_reg  <= 16'h0000;
      hyst_reg  <= LINES'(`IOPC_HYST_RST);
      mask_reg  <= `IOPC_MASK_RST;
    end else begin
      if (wr_go && wa_wpm && key_ok) begin
        pen_reg <= wd[`IOPC_PEN_BIT];
      end
      if (viol) begin
        vflag_reg <= 1'b1;
        vofs_reg  <= vofs_w[15:0];
      end else if (rd_wps) begin
        vflag_reg <= 1'b0;
      end
      if (wr_go && wa_hyst) begin
        hyst_reg <= (hyst_reg & ~wmask[LINES-1:0]) | wd[LINES-1:0];
      end
      mask_reg <= (mask_reg | en_bits) & ~dis_bits;
    end
  end
  assign hysteresis_off = hyst_reg;

  // capture mode fields
  // a reserved width code is stored as written; the packer treats it as a byte
  wire                     cap_en = cmode_reg[`IOPC_CEN_BIT];
  iopc_pkg::iopc_width_t   width;
  assign width = iopc_pkg::iopc_width_t'(cmode_reg[`IOPC_WID_MSB:`IOPC_WID_LSB]);
  wire                     alw    = cmode_reg[`IOPC_ALW_BIT];
  wire                     alt    = cmode_reg[`IOPC_ALT_BIT];
  wire                     phase  = cmode_reg[`IOPC_PH_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmode_reg <= `IOPC_CMODE_RST;
    end else if (cmode_we) begin
      cmode_reg <= ((cmode_reg & ~wmask) | wd) & `IOPC_CMODE_WMASK;
    end
  end

  // sample qualification: enables, alternate selection and phase
  // the parity bit counts every qualifying sample, kept or not
  wire qual = cap_en && cap_strobe && (alw || (cap_den1 && cap_den2));
  wire keep = qual && (!alt || idx_reg == phase);

  // bytes per word minus one; reserved code packs like a byte
  // limitation: one byte per cycle, so a 32-bit word takes at least four kept samples
  logic [1:0] last_cnt;
  always_comb begin
    case (width)
      iopc_pkg::IOPC_W16: last_cnt = 2'h1;
      iopc_pkg::IOPC_W32: last_cnt = 2'h3;
      default:            last_cnt = 2'h0;
    endcase
  end

  // first kept byte lands in the low lane; upper lanes stay zero at narrow width
  wire [4:0]  sh   = {cnt_reg, 3'h0};
  wire [31:0] ins  = 32'(cap_data) << sh;
  wire [31:0] bmsk = 32'h000000FF << sh;
  wire [31:0] asm_w = (pack_reg & ~bmsk) | ins;
  wire        done = keep && cnt_reg == last_cnt;

  // packing state restarts on any mode change so a width switch never mixes words
  // a word completed in the cycle of a mode write is dropped with the rest
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_reg  <= 1'b0;
      cnt_reg  <= 2'h0;
      pack_reg <= 32'h00000000;
      hold_reg <= 32'h00000000;
    end else begin
      if (!cap_en || cmode_we) begin
        idx_reg  <= 1'b0;
        cnt_reg  <= 2'h0;
        pack_reg <= 32'h00000000;
      end else begin
        if (qual) begin
          idx_reg <= !idx_reg;
        end
        if (done) begin
          cnt_reg  <= 2'h0;
          pack_reg <= 32'h00000000;
        end else if (keep) begin
          cnt_reg  <= cnt_reg + 2'h1;
          pack_reg <= asm_w;
        end
      end
      if (done && !cmode_we) begin
        hold_reg <= asm_w;
      end
    end
  end

  // capture flags: a new word wins over a clearing read in the same cycle
  // switching capture off drops both flags but leaves the last word readable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdy_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end else if (!cap_en) begin
      rdy_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end else begin
      if (done && !cmode_we) begin
        rdy_reg <= 1'b1;
      end else if (rd_hold) begin
        rdy_reg <= 1'b0;
      end
      if (done && !cmode_we && rdy_reg && !rd_hold) begin
        ovr_reg <= 1'b1;
      end else if (rd_istat) begin
        ovr_reg <= 1'b0;
      end
    end
  end

  // registered interrupt, one cycle behind the flags
  // the extra cycle of latency buys a glitch-free output for the interrupt controller
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_w & mask_reg);
    end
  end
  assign cap_irq = irq_reg;

endmodule

/* File: iopc_top_tb.sv */
// self-checking bench for the protect and capture block
`timescale 1ns/100ps
`include "iopc_map.svh"
module iopc_top_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cap_strobe, cap_den1, cap_den2, cap_irq;
  logic        rx_transfer_end, rx_buffer_full;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, line_locked, hysteresis_off, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp;
  logic [7:0]  cap_data;
  int          mismatches, samples_checked;
  // capture cases: mode, bytes low first, per-byte enable, count, expected holding word
  logic [31:0] cm_tab [7] = '{32'h1, 32'h11, 32'h21, 32'h411, 32'hC11, 32'h1, 32'h201};
  logic [31:0] by_tab [7] = '{32'h5A, 32'h1234, 32'h11223344, 32'h13121110, 32'h13121110, 32'h5577, 32'h66};
  logic [3:0]  de_tab [7] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'h2, 4'h0};
  int          nb_tab [7] = '{1, 2, 4, 4, 4, 2, 1};
  logic [31:0] ex_tab [7] = '{32'h5A, 32'h1234, 32'h11223344, 32'h1210, 32'h1311, 32'h55, 32'h66};
  iopc_top u_iopc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_locked, .hysteresis_off,
    .cap_data, .cap_strobe, .cap_den1, .cap_den2, .rx_transfer_end, .rx_buffer_full, .cap_irq);
  iopc_cap_src u_iopc_cap_src (.aclk, .cap_data, .cap_strobe, .cap_den1, .cap_den2, .rx_transfer_end, .rx_buffer_full);
  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // address and data offered together; bready held until the response edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) mismatches++;
    if (n >= 50) report_and_stop();
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n >= 50) mismatches++;
    if (n >= 50) report_and_stop();
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    rd(a, rdat, rrsp);
    chk(rdat, exp);
    chk({30'h0, rrsp}, {30'h0, `IOPC_RESP_OK});
  endtask
  // the interrupt is registered, so allow a few cycles before judging it
  task automatic irq_is(input logic exp);
    int n;
    for (n = 0; n < 8 && cap_irq !== exp; n++) @(posedge aclk);
    chk({31'h0, cap_irq}, {31'h0, exp});
  endtask
  // main sequence
  initial begin
    mismatches      = 0;
    samples_checked = 0;
    aresetn         = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb     = 4'hF;
    line_locked     = 32'hA5C30F81;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`IOPC_A_HYST, 32'h0);
    rdc(`IOPC_A_CMODE, 32'h0);
    rdc(`IOPC_A_IMASK, 32'h0);
    wr(`IOPC_A_LOCK, 32'hFFFFFFFF);
    rdc(`IOPC_A_LOCK, 32'hA5C30F81);
    wr(`IOPC_A_HYST, 32'h80000001);
    rdc(`IOPC_A_HYST, 32'h80000001);
    chk(hysteresis_off, 32'h80000001);
    wr(32'h400E0F70, 32'h1, `IOPC_RESP_ERR);
    rd(32'h400E0F70, rdat, rrsp);
    chk({30'h0, rrsp}, {30'h0, `IOPC_RESP_ERR});
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      wr(`IOPC_A_CMODE, 32'h0);
      wr(`IOPC_A_CMODE, cm_tab[i]);
      for (int k = 0; k < nb_tab[i]; k++) u_iopc_cap_src.send(by_tab[i][8*k+:8], de_tab[i][k], k % 2);
      rdc(`IOPC_A_HOLD, ex_tab[i]);
    end
    wr(`IOPC_A_CMODE, 32'hFFFFFFFF);
    rdc(`IOPC_A_CMODE, 32'hE31);
    wr(`IOPC_A_CMODE, 32'h1);
    $display("test capture done");
    wr(`IOPC_A_IEN, 32'h3);
    rdc(`IOPC_A_IMASK, 32'h3);
    u_iopc_cap_src.send(8'h21, 1'b1, 0);
    irq_is(1'b1);
    u_iopc_cap_src.send(8'h22, 1'b1, 0);
    rdc(`IOPC_A_ISTAT, 32'h3);
    rdc(`IOPC_A_ISTAT, 32'h1);
    rdc(`IOPC_A_HOLD, 32'h22);
    rdc(`IOPC_A_ISTAT, 32'h0);
    irq_is(1'b0);
    u_iopc_cap_src.send(8'h23, 1'b1, 0);
    wr(`IOPC_A_CMODE, 32'h0);
    rdc(`IOPC_A_ISTAT, 32'h0);
    wr(`IOPC_A_IDIS, 32'h1);
    wr(`IOPC_A_IEN, 32'h0);
    rdc(`IOPC_A_IMASK, 32'h2);
    u_iopc_cap_src.dma(1'b1, 1'b1);
    rdc(`IOPC_A_ISTAT, 32'hC);
    irq_is(1'b0);
    wr(`IOPC_A_IEN, 32'h8);
    irq_is(1'b1);
    wr(`IOPC_A_IDIS, 32'hF);
    irq_is(1'b0);
    wr(`IOPC_A_IEN, 32'h4);
    irq_is(1'b1);
    u_iopc_cap_src.dma(1'b0, 1'b0);
    irq_is(1'b0);
    wr(`IOPC_A_IDIS, 32'hF);
    $display("test interrupts done");
    wr(`IOPC_A_WPMODE, 32'h12345601);
    rdc(`IOPC_A_WPMODE, 32'h0);
    wr(`IOPC_A_WPMODE, 32'h50494F01);
    rdc(`IOPC_A_WPMODE, 32'h1);
    wr(`IOPC_A_CMODE, 32'h21);
    rdc(`IOPC_A_CMODE, 32'h0);
    rdc(`IOPC_A_WPSTAT, 32'h15001);
    rdc(`IOPC_A_WPSTAT, 32'h15000);
    wr(`IOPC_A_WPMODE, 32'h0);
    rdc(`IOPC_A_WPMODE, 32'h1);
    wr(`IOPC_A_WPMODE, 32'h50494F00);
    wr(`IOPC_A_CMODE, 32'h21);
    rdc(`IOPC_A_CMODE, 32'h21);
    $display("test protection done");
    report_and_stop();
  end
endmodule
